/* pkg/plobl_pkg.sv */
// Shared constants and types for the PID loop output and bias limiter.
// Assumes reals are carried as signed fixed point with FRAC fraction bits.
package plobl_pkg;
   localparam int W = 32;
   localparam int FRAC = 24;
   localparam int NB = W + FRAC;
   localparam int CNT_W = 6;
   localparam int IDX_W = 2;
   localparam logic signed [W-1:0] ZERO = 32'h00000000;
   localparam logic signed [W-1:0] HALF = 32'h00800000;
   localparam logic signed [W-1:0] ONE = 32'h01000000;
   // Typical spans, kept for software and bench use
   localparam logic signed [W-1:0] SPAN_UNIPOLAR = 32'h00007d00;
   localparam logic signed [W-1:0] SPAN_BIPOLAR = 32'h0000fa00;
   localparam logic signed [2*W-1:0] ROUND_HALF = 64'h0000000000800000;
   localparam logic signed [2*W-1:0] ANALOG_MAX = 64'h0000000000007fff;
   localparam logic signed [2*W-1:0] ANALOG_MIN = 64'hffffffffffff8000;
   localparam logic [IDX_W-1:0] IDX_PV = 2'h0;
   localparam logic [IDX_W-1:0] IDX_SP = 2'h1;
   localparam logic [IDX_W-1:0] IDX_KI = 2'h2;
   localparam logic [IDX_W-1:0] IDX_KD = 2'h3;

   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_ISSUE = 3'h1,
      S_WAIT = 3'h2,
      S_TERMS = 3'h3,
      S_WB = 3'h4
   } plobl_state_t;
endpackage

/* pkg/plobl_div_if.sv */
// Request/answer channel between the loop engine and its divider.
// Assumes one clock; req and ack are single-cycle pulses.
`timescale 1ns/1ns
`default_nettype none
interface plobl_div_if;
   logic req;
   logic signed [plobl_pkg::W-1:0] dividend;
   logic signed [plobl_pkg::W-1:0] divisor;
   logic ack;
   logic signed [plobl_pkg::W-1:0] quot;
   modport master (output req, output dividend, output divisor, input ack, input quot);
   modport slave (input req, input dividend, input divisor, output ack, output quot);
endinterface
`default_nettype wire

/* verilog/plobl_div.sv */
// Sequential signed fixed-point divider: quot = (dividend << FRAC) / divisor.
// Assumes the master holds operands only in the req cycle and waits for ack.
`timescale 1ns/1ns
`default_nettype none
module plobl_div (
   input wire logic mclk,
   input wire logic rst,
   plobl_div_if.slave dport
);
   import plobl_pkg::*;

   logic busy_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic [W:0] rem_ff;
   logic [NB-1:0] num_ff;
   logic [W-1:0] den_ff;
   logic neg_ff;
   logic ack_ff;
   logic signed [W-1:0] quot_ff;

   wire logic [W-1:0] mag_a = dport.dividend[W-1] ? W'(-dport.dividend) : dport.dividend;
   wire logic [W-1:0] mag_b = dport.divisor[W-1] ? W'(-dport.divisor) : dport.divisor;
   wire logic [W:0] shifted = {rem_ff[W-1:0], num_ff[NB-1]};
   wire logic [W:0] diff = shifted - {1'b0, den_ff};
   wire logic fits = ~diff[W];
   wire logic [NB-1:0] num_next = {num_ff[NB-2:0], fits};
   wire logic last = (cnt_ff == CNT_W'(NB-1));
   wire logic [W-1:0] q_mag = num_next[W-1:0];

   // ----------------------------------------
   // Restoring division, one quotient bit per cycle
   // ----------------------------------------
   // A zero divisor answers zero: an unset integral time then means no integral action.
   always_ff @(posedge mclk) begin
      if (rst) begin
         busy_ff <= 1'b0;
         cnt_ff <= '0;
         rem_ff <= '0;
         num_ff <= '0;
         den_ff <= '0;
         neg_ff <= 1'b0;
         ack_ff <= 1'b0;
         quot_ff <= ZERO;
      end else begin
         ack_ff <= 1'b0;
         if (dport.req && !busy_ff) begin
            if (dport.divisor == ZERO) begin
               ack_ff <= 1'b1;
               quot_ff <= ZERO;
            end else begin
               busy_ff <= 1'b1;
               cnt_ff <= '0;
               rem_ff <= '0;
               num_ff <= {mag_a, {FRAC{1'b0}}};
               den_ff <= mag_b;
               neg_ff <= dport.dividend[W-1] ^ dport.divisor[W-1];
            end
         end else if (busy_ff) begin
            rem_ff <= fits ? diff : shifted;
            num_ff <= num_next;
            cnt_ff <= cnt_ff + 1'b1;
            if (last) begin
               busy_ff <= 1'b0;
               ack_ff <= 1'b1;
               quot_ff <= neg_ff ? W'(-q_mag) : q_mag;
            end
         end
      end
   end

   assign dport.ack = ack_ff;
   assign dport.quot = quot_ff;

   AST_DIV_ANSWERS: assert property (@(posedge mclk) disable iff (rst) // R19
      (dport.req && !busy_ff) |-> ##[1:60] ack_ff)
      else $error("divider gave no answer in time");
endmodule
`default_nettype wire

/* verilog/plobl_top.sv */
// PID loop step: input normalization, P/I/D terms, output and bias limiting,
// write-back of loop variables and scaling of the output to a 16-bit integer.
// Assumes all inputs come from logic on mclk and stay stable while busy is high.
//
// How it works
// R01 - Raw 16-bit signed readings are sign-widened to 32 bits before conversion.
// R02 - Normalized input is raw value over span plus 0.0 or 0.5 offset.
// R03 - One span, max minus min raw value, serves inputs and output.
// R04 - Scaled output is loop output minus offset, times span.
// R05 - Scaled output is rounded to integer then reduced to 16 bits.
// R06 - Positive gain acts forward, negative gain acts in reverse.
// R07 - With zero gain, sign of integral and derivative times sets direction.
// R08 - Setpoint and process values are only read, never written.
// R09 - New loop output is written back at the end of each calculation.
// R10 - Written-back loop output is limited to 0.0 through 1.0.
// R11 - Controller may preload the loop output before switching to automatic.
// R12 - With integral action, the bias is updated and feeds the next calculation.
// R13 - Output above 1.0 sets bias to 1.0 minus proportional plus derivative.
// R14 - Output below 0.0 sets bias to negated proportional plus derivative.
// R15 - Bias is limited to 0.0 through 1.0 and stored at completion.
// R16 - Controller may overwrite the bias; values must lie in 0.0 to 1.0.
// R17 - Previous process value is kept for the derivative term.
// R18 - Proportional term is gain times setpoint minus process value.
// R19 - Integral term is gain times period over integral time times error plus bias.
// R20 - On the first sample the previous process value equals the current one.
// R21 - Zero gain is replaced by 1.0 in the integral and derivative terms.
// R22 - Start pulse begins a calculation; done pulse marks valid write-backs.
`timescale 1ns/1ns
`default_nettype none
module plobl_top (
   input wire logic mclk,
   input wire logic rst,
   input wire logic start,
   input wire logic first_sample,
   input wire logic bipolar,
   input wire logic signed [plobl_pkg::W-1:0] span_value,
   input wire logic signed [15:0] raw_process,
   input wire logic signed [15:0] raw_setpoint,
   input wire logic signed [plobl_pkg::W-1:0] loop_gain,
   input wire logic signed [plobl_pkg::W-1:0] sample_period,
   input wire logic signed [plobl_pkg::W-1:0] integral_time,
   input wire logic signed [plobl_pkg::W-1:0] derivative_time,
   input wire logic output_wr,
   input wire logic signed [plobl_pkg::W-1:0] output_wr_value,
   input wire logic bias_wr,
   input wire logic signed [plobl_pkg::W-1:0] bias_wr_value,
   output logic signed [plobl_pkg::W-1:0] loop_output,
   output logic signed [plobl_pkg::W-1:0] integral_bias,
   output logic signed [plobl_pkg::W-1:0] previous_process_value,
   output logic signed [15:0] analog_out,
   output logic busy,
   output logic done
);
   import plobl_pkg::*;

   function automatic logic signed [W-1:0] fmul(input logic signed [W-1:0] a, input logic signed [W-1:0] b);
      logic signed [2*W-1:0] p;
      p = a * b;
      return p[FRAC+W-1:FRAC];
   endfunction

   function automatic logic signed [W-1:0] clamp01(input logic signed [W-1:0] v);
      return (v > ONE) ? ONE : ((v < ZERO) ? ZERO : v);
   endfunction

   plobl_state_t state_ff, nxt_state;
   logic [IDX_W-1:0] idx_ff;
   logic signed [W-1:0] quot_ff [0:3];
   logic signed [W-1:0] mp_ff, mi_ff, md_ff;
   logic first_ff;
   logic signed [W-1:0] loop_output_ff, integral_bias_ff, previous_process_value_ff;
   logic signed [15:0] analog_out_ff;
   logic busy_ff, done_ff;

   plobl_div_if dif ();

   plobl_div u_div (
      .mclk(mclk),
      .rst(rst),
      .dport(dif.slave)
   );

   // ----------------------------------------
   // Divider operand selection
   // ----------------------------------------
   wire logic signed [W-1:0] raw_pv_ext = {{(W-16){raw_process[15]}}, raw_process}; // R01
   wire logic signed [W-1:0] raw_sp_ext = {{(W-16){raw_setpoint[15]}}, raw_setpoint}; // R01
   wire logic use_span = (idx_ff == IDX_PV) || (idx_ff == IDX_SP);
   wire logic signed [W-1:0] div_a = (idx_ff == IDX_PV) ? raw_pv_ext :
                                     (idx_ff == IDX_SP) ? raw_sp_ext :
                                     (idx_ff == IDX_KI) ? sample_period : derivative_time;
   wire logic signed [W-1:0] div_b = use_span ? span_value : // R03
                                     (idx_ff == IDX_KI) ? integral_time : sample_period;
   assign dif.req = (state_ff == S_ISSUE);
   assign dif.dividend = div_a;
   assign dif.divisor = div_b;

   // ----------------------------------------
   // Terms of the loop equation
   // ----------------------------------------
   wire logic signed [W-1:0] offset = bipolar ? HALF : ZERO;
   wire logic signed [W-1:0] pv_norm = quot_ff[IDX_PV] + offset; // R02
   wire logic signed [W-1:0] sp_norm = quot_ff[IDX_SP] + offset; // R02
   wire logic signed [W-1:0] err = sp_norm - pv_norm;
   wire logic signed [W-1:0] gain_eff = (loop_gain == ZERO) ? ONE : loop_gain; // R21
   // Integral time of zero makes the ratio zero: no integral action, bias left alone
   wire logic int_on = (quot_ff[IDX_KI] != ZERO);
   wire logic signed [W-1:0] prev_sel = first_ff ? pv_norm : previous_process_value_ff; // R20
   // Signs flow through the products, so direction follows gain, or times at zero gain
   wire logic signed [W-1:0] mp_w = fmul(loop_gain, err); // R18 R06
   wire logic signed [W-1:0] mi_w = fmul(fmul(gain_eff, quot_ff[IDX_KI]), err) + integral_bias_ff; // R19 R07
   wire logic signed [W-1:0] md_w = fmul(fmul(gain_eff, quot_ff[IDX_KD]), prev_sel - pv_norm); // R07 R17

   // ----------------------------------------
   // Limiting and bias back-calculation
   // ----------------------------------------
   wire logic signed [W-1:0] pd_sum = mp_ff + md_ff;
   wire logic signed [W-1:0] out_raw = pd_sum + mi_ff;
   wire logic out_hi = (out_raw > ONE);
   wire logic out_lo = (out_raw < ZERO);
   wire logic signed [W-1:0] out_lim = clamp01(out_raw); // R10
   wire logic signed [W-1:0] bias_adj = out_hi ? ONE - pd_sum : // R13
                                        out_lo ? -pd_sum : mi_ff; // R14
   wire logic signed [W-1:0] bias_lim = clamp01(bias_adj); // R15
   // Reference values for the checks below, formed apart from the mux above
   wire logic signed [W-1:0] bias_hi_ref = clamp01(ONE - pd_sum);
   wire logic signed [W-1:0] bias_lo_ref = clamp01(ZERO - pd_sum);

   // ----------------------------------------
   // Output scaling to 16-bit integer
   // ----------------------------------------
   wire logic signed [W-1:0] out_off = out_lim - offset; // R04
   wire logic signed [2*W-1:0] out_off64 = {{W{out_off[W-1]}}, out_off};
   wire logic signed [2*W-1:0] span64 = {{W{span_value[W-1]}}, span_value};
   wire logic signed [2*W-1:0] scaled_output_value = out_off64 * span64; // R04
   // Rounds half up; beyond 16 bits the value saturates instead of wrapping
   wire logic signed [2*W-1:0] rounded = (scaled_output_value + ROUND_HALF) >>> FRAC; // R05
   wire logic signed [15:0] analog_w = (rounded > ANALOG_MAX) ? 16'h7fff :
                                       (rounded < ANALOG_MIN) ? 16'h8000 : rounded[15:0]; // R05

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   wire logic last_div = (idx_ff == IDX_KD);
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         S_IDLE: begin
            if (start) begin
               nxt_state = S_ISSUE; // R22
            end
         end
         S_ISSUE: nxt_state = S_WAIT;
         S_WAIT: begin
            if (dif.ack) begin
               nxt_state = last_div ? S_TERMS : S_ISSUE;
            end
         end
         S_TERMS: nxt_state = S_WB;
         S_WB: nxt_state = S_IDLE;
         default: nxt_state = S_IDLE;
      endcase
   end

   wire logic idle = (state_ff == S_IDLE);
   wire logic wb = (state_ff == S_WB);

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_ff <= S_IDLE;
         idx_ff <= IDX_PV;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         busy_ff <= (nxt_state != S_IDLE);
         done_ff <= wb; // R22
         if (idle) begin
            idx_ff <= IDX_PV;
         end else if (state_ff == S_WAIT && dif.ack) begin
            idx_ff <= idx_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         quot_ff <= '{default: ZERO};
         mp_ff <= ZERO;
         mi_ff <= ZERO;
         md_ff <= ZERO;
      end else begin
         if (state_ff == S_WAIT && dif.ack) begin
            quot_ff[idx_ff] <= dif.quot;
         end
         if (state_ff == S_TERMS) begin
            mp_ff <= mp_w;
            mi_ff <= mi_w;
            md_ff <= md_w;
         end
      end
   end

   // ----------------------------------------
   // Loop variables and write-back
   // ----------------------------------------
   // Setpoint and process value have no storage here, so nothing can write them (R08).
   // Controller writes are taken only while idle so a calculation sees stable values.
   always_ff @(posedge mclk) begin
      if (rst) begin
         loop_output_ff <= ZERO;
         integral_bias_ff <= ZERO;
         previous_process_value_ff <= ZERO;
         analog_out_ff <= 16'h0000;
         first_ff <= 1'b1;
      end else begin
         if (wb) begin
            loop_output_ff <= out_lim; // R09
            analog_out_ff <= analog_w;
            previous_process_value_ff <= pv_norm; // R17
         end else if (idle && output_wr) begin
            loop_output_ff <= output_wr_value; // R11
         end
         if (wb && int_on) begin
            integral_bias_ff <= bias_lim; // R12
         end else if (idle && bias_wr) begin
            integral_bias_ff <= bias_wr_value; // R16
         end
         // A restart request in the write-back cycle wins over the clear
         if (first_sample) begin
            first_ff <= 1'b1;
         end else if (wb) begin
            first_ff <= 1'b0;
         end
      end
   end

   assign loop_output = loop_output_ff;
   assign integral_bias = integral_bias_ff;
   assign previous_process_value = previous_process_value_ff;
   assign analog_out = analog_out_ff;
   assign busy = busy_ff;
   assign done = done_ff;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_START_TO_DONE: assert property (@(posedge mclk) disable iff (rst) // R22
      (idle && start) |-> ##[1:300] done_ff)
      else $error("calculation did not finish in time");
   AST_DONE_PULSE: assert property (@(posedge mclk) disable iff (rst) // R22
      done_ff |=> !done_ff)
      else $error("done longer than one cycle");
   AST_OUT_RANGE: assert property (@(posedge mclk) disable iff (rst) // R10
      done_ff |-> (loop_output_ff >= ZERO) && (loop_output_ff <= ONE))
      else $error("loop output out of range at done");
   AST_OUT_WRITTEN: assert property (@(posedge mclk) disable iff (rst) // R09
      wb |=> (loop_output_ff == $past(out_lim)) && done_ff)
      else $error("loop output not written back");
   AST_BIAS_HIGH: assert property (@(posedge mclk) disable iff (rst) // R13
      (wb && int_on && out_hi) |=> integral_bias_ff == $past(bias_hi_ref))
      else $error("bias not adjusted on high saturation");
   AST_BIAS_LOW: assert property (@(posedge mclk) disable iff (rst) // R14
      (wb && int_on && out_lo) |=> integral_bias_ff == $past(bias_lo_ref))
      else $error("bias not adjusted on low saturation");
   AST_BIAS_RANGE: assert property (@(posedge mclk) disable iff (rst) // R15
      (wb && int_on) |=> (integral_bias_ff >= ZERO) && (integral_bias_ff <= ONE))
      else $error("stored bias out of range");
   AST_FIRST_NO_DERIV: assert property (@(posedge mclk) disable iff (rst) // R20
      (state_ff == S_TERMS && first_ff) |=> md_ff == ZERO)
      else $error("derivative not zero on first sample");
   AST_PREV_KEPT: assert property (@(posedge mclk) disable iff (rst) // R17
      (!wb) |=> $stable(previous_process_value_ff))
      else $error("previous process value changed outside write-back");

   // ----------------------------------------
   // Holding and sequencing checks
   // ----------------------------------------
   // Controller writes land only while idle, so stored values hold through a calculation
   AST_BIAS_HELD: assert property (@(posedge mclk) disable iff (rst) // R16
      (busy_ff && !wb) |=> $stable(integral_bias_ff))
      else $error("bias changed during a calculation");
   AST_OUT_HELD: assert property (@(posedge mclk) disable iff (rst) // R11
      (busy_ff && !wb) |=> $stable(loop_output_ff))
      else $error("loop output changed during a calculation");
   AST_NO_INT_KEEPS_BIAS: assert property (@(posedge mclk) disable iff (rst) // R12
      (wb && !int_on) |=> $stable(integral_bias_ff))
      else $error("bias changed without integral action");
   AST_BUSY_FROM_START: assert property (@(posedge mclk) disable iff (rst) // R22
      (idle && start) |=> busy_ff && !done_ff)
      else $error("busy not raised after start");
   AST_DONE_NOT_BUSY: assert property (@(posedge mclk) disable iff (rst) // R22
      done_ff |-> !busy_ff && idle)
      else $error("busy still high at done");
   AST_FIRST_CLEARED: assert property (@(posedge mclk) disable iff (rst) // R20
      (wb && !first_sample) |=> !first_ff)
      else $error("first-sample flag not cleared after write-back");
   AST_ZERO_GAIN_NO_P: assert property (@(posedge mclk) disable iff (rst) // R18
      (state_ff == S_TERMS && loop_gain == ZERO) |=> mp_ff == ZERO)
      else $error("proportional term not zero at zero gain");
   AST_PREV_WRITTEN: assert property (@(posedge mclk) disable iff (rst) // R17
      wb |=> previous_process_value_ff == $past(pv_norm))
      else $error("previous process value not written back");
endmodule
`default_nettype wire

/* test/plobl_tb.sv */
// Self-checking bench for plobl_top: a longint model of the loop step is compared at every done.
// Assumes plobl_pkg and the design files are compiled first; inputs move on the falling edge.
`timescale 1ns/1ns
`default_nettype none
module tb;
   import plobl_pkg::*;
   logic mclk, rst, start, first_sample, bipolar, output_wr, bias_wr, busy, done;
   logic signed [W-1:0] span_value, loop_gain, sample_period, integral_time, derivative_time;
   logic signed [W-1:0] output_wr_value, bias_wr_value, loop_output, integral_bias, previous_process_value;
   logic signed [15:0] raw_process, raw_setpoint, analog_out;
   int mismatches, tests_run, k, rp, rs;
   longint m_out, m_bias, m_prev, m_ana, per, itg;
   bit m_first, bp;
   // ----------------------------------------
   // Device under test
   // ----------------------------------------
   plobl_top uut (.mclk(mclk), .rst(rst), .start(start), .first_sample(first_sample), .bipolar(bipolar),
      .span_value(span_value), .raw_process(raw_process), .raw_setpoint(raw_setpoint), .loop_gain(loop_gain),
      .sample_period(sample_period), .integral_time(integral_time), .derivative_time(derivative_time),
      .output_wr(output_wr), .output_wr_value(output_wr_value), .bias_wr(bias_wr),
      .bias_wr_value(bias_wr_value), .loop_output(loop_output), .integral_bias(integral_bias),
      .previous_process_value(previous_process_value), .analog_out(analog_out), .busy(busy), .done(done));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // ----------------------------------------
   // Compare and closing tasks
   // ----------------------------------------
   // Tolerance absorbs truncation order inside the fixed-point datapath
   task automatic chk_val(input string what, input logic signed [W-1:0] got, input longint exp, input longint tol);
      longint d;
      d = longint'(got) - exp;
      tests_run++;
      if ((^got) === 1'bx || d > tol || d < -tol) begin
         mismatches++;
         $display("BAD t=%0t %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask
   task automatic chk_flag(input string what, input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Reference model
   // ----------------------------------------
   task automatic model(input bit bip, input longint span, r_pv, r_sp, g, per, itg, der);
      longint off, pv, sp, prv, ge, e, p, ki, kd, i, d, m, nb;
      off = bip ? longint'(HALF) : 0;
      pv = (span == 0) ? off : ((r_pv <<< 24) / span) + off;
      sp = (span == 0) ? off : ((r_sp <<< 24) / span) + off;
      prv = m_first ? pv : m_prev;
      ge = (g == 0) ? longint'(ONE) : g;
      e = sp - pv;
      p = (g * e) >>> 24;
      ki = (itg == 0) ? 0 : (per <<< 24) / itg;
      kd = (per == 0) ? 0 : (der <<< 24) / per;
      i = ((((ge * ki) >>> 24) * e) >>> 24) + m_bias;
      d = ((((ge * kd) >>> 24) * (prv - pv)) >>> 24);
      m = p + i + d;
      if (itg != 0) begin
         nb = (m > ONE) ? ONE - (p + d) : ((m < 0) ? -(p + d) : i);
         m_bias = (nb < 0) ? 0 : ((nb > ONE) ? longint'(ONE) : nb);
      end
      m_out = (m < 0) ? 0 : ((m > ONE) ? longint'(ONE) : m);
      m_prev = pv;
      m_first = 1'b0;
      m_ana = (((m_out - off) * span) + HALF) >>> 24;
      m_ana = (m_ana > 32767) ? 32767 : ((m_ana < -32768) ? -32768 : m_ana);
   endtask
   // ----------------------------------------
   // Stimulus tasks (called at a falling edge)
   // ----------------------------------------
   task automatic preset(input longint o, input longint b);
      output_wr = 1'b1;
      output_wr_value = W'(o);
      bias_wr = 1'b1;
      bias_wr_value = W'(b);
      @(negedge mclk);
      output_wr = 1'b0;
      bias_wr = 1'b0;
      m_out = o;
      m_bias = b;
      chk_val("preload out", loop_output, o, 0);
      chk_val("preload bias", integral_bias, b, 0);
   endtask
   task automatic calc(input bit bip, input int r_pv, r_sp, input longint g, per, itg, der, input bit poke);
      int n;
      longint span;
      span = bip ? 64000 : 32000;
      bipolar = bip;
      span_value = W'(span);
      raw_process = 16'(r_pv);
      raw_setpoint = 16'(r_sp);
      loop_gain = W'(g);
      sample_period = W'(per);
      integral_time = W'(itg);
      derivative_time = W'(der);
      start = 1'b1;
      model(bip, span, r_pv, r_sp, g, per, itg, der);
      @(negedge mclk);
      start = poke;
      bias_wr = poke;
      output_wr = poke;
      bias_wr_value = ONE;
      output_wr_value = ZERO;
      chk_flag("busy after start", busy, 1'b1);
      @(negedge mclk);
      start = 1'b0;
      bias_wr = 1'b0;
      output_wr = 1'b0;
      n = 2;
      while (done !== 1'b1 && n < 400) begin
         @(negedge mclk);
         n++;
      end
      chk_flag("done", done, 1'b1);
      chk_flag("latency", n <= 300, 1'b1);
      chk_flag("busy at done", busy, 1'b0);
      chk_val("loop output", loop_output, m_out, 1024);
      chk_val("bias", integral_bias, m_bias, 1024);
      chk_val("prev pv", previous_process_value, m_prev, 64);
      chk_val("analog", {{16{analog_out[15]}}, analog_out}, m_ana, 3);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      #1000000;
      mismatches++;
      $display("BAD t=%0t watchdog expired", $time);
      end_sim();
   end
   initial begin
      {rst, start, first_sample, bipolar, output_wr, bias_wr} = 6'h20;
      {span_value, loop_gain, sample_period, integral_time, derivative_time} = '0;
      {output_wr_value, bias_wr_value, raw_process, raw_setpoint} = '0;
      mismatches = 0;
      tests_run = 0;
      void'($urandom(32'hbddb8cfe));
      {m_out, m_bias, m_prev, m_first} = {64'h0, 64'h0, 64'h0, 1'b1};
      repeat (20) @(negedge mclk);
      rst = 1'b0;
      chk_val("reset out", loop_output, 0, 0);
      chk_flag("reset busy", busy, 1'b0);
      // Saturation high, then low, with preset bias
      preset(HALF, 32'h00e66666);
      calc(0, 9600, 19200, ONE, ONE, ONE, 0, 0);
      preset(ZERO, 32'h0019999a);
      calc(0, 16000, 9600, ONE, 32'h00400000, ONE, 0, 0);
      // Direction by gain sign and by time sign at zero gain
      calc(0, 12000, 20000, ONE, 32'h00400000, 32'h04000000, 32'h00200000, 0);
      calc(0, 20000, 12000, -ONE, 32'h00400000, 32'h04000000, 32'h00200000, 0);
      calc(1, -4000, 3000, 0, 32'h00400000, 32'h04000000, 32'h00200000, 0);
      calc(1, 3000, -4000, 0, 32'h00400000, -32'sh04000000, -32'sh00200000, 0);
      // No integral action keeps bias; refused writes and start while busy
      calc(0, 8000, 24000, HALF, ONE, 0, 32'h00400000, 1);
      repeat (3) begin
         @(negedge mclk);
         chk_flag("idle stays idle", busy, 1'b0);
      end
      first_sample = 1'b1;
      m_first = 1'b1;
      @(negedge mclk);
      first_sample = 1'b0;
      calc(0, 30000, 16000, ONE, 32'h00400000, 32'h08000000, ONE, 0);
      for (k = 0; k < 30; k++) begin
         bp = $urandom_range(0, 1);
         rp = bp ? int'($urandom_range(0, 64000)) - 32000 : int'($urandom_range(0, 32000));
         rs = bp ? int'($urandom_range(0, 64000)) - 32000 : int'($urandom_range(0, 32000));
         per = $urandom_range(32'h0019999a, ONE);
         itg = ($urandom_range(0, 4) == 0) ? 0 : longint'($urandom_range(ONE, 32'h3c000000));
         calc(bp, rp, rs, longint'($urandom_range(0, 32'h04000000)) - 32'h02000000, per, itg,
            $urandom_range(0, per), k[0]);
      end
      // Second reset in mid-run restores the start-up state
      calc(0, 100, 200, ONE, ONE, ONE, 0, 0);
      start = 1'b1;
      @(negedge mclk);
      start = 1'b0;
      rst = 1'b1;
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      chk_flag("reset mid-run busy", busy, 1'b0);
      chk_val("reset mid-run bias", integral_bias, 0, 0);
      chk_val("reset mid-run out", loop_output, 0, 0);
      {m_out, m_bias, m_prev, m_first} = {64'h0, 64'h0, 64'h0, 1'b1};
      // First start waits one edge past the first edge that sees reset low
      @(negedge mclk);
      calc(0, 16000, 16000, ONE, ONE, ONE, ONE, 0);
      end_sim();
   end
endmodule
`default_nettype wire
